/* logic/dbit_params.svh */
// register map, field positions, reset values and timing constants
`ifndef DBIT_PARAMS_SVH
`define DBIT_PARAMS_SVH

`define DBIT_OFS_PORT_IRQ_EN   8'h00
`define DBIT_OFS_BOARD_IRQ_CTL 8'h04
`define DBIT_OFS_IRQ_CLEAR     8'h08
`define DBIT_OFS_PPI_CTL       8'h0C
`define DBIT_OFS_TIMER0_COUNT  8'h10
`define DBIT_OFS_TIMER1_COUNT  8'h14
`define DBIT_OFS_TIMER_CTL     8'h18
`define DBIT_OFS_STATUS        8'h1C

`define DBIT_PIE_PORTA_BIT     0
`define DBIT_BIC_SRC_SEL_BIT   0
`define DBIT_BIC_CTR_EN_BIT    1
`define DBIT_BIC_MASTER_BIT    2

`define DBIT_PPI_MODESET_BIT   7
`define DBIT_PPI_MODE_HI       6
`define DBIT_PPI_MODE_LO       5
`define DBIT_PPI_DIR_IN_BIT    4
`define DBIT_PPI_BSR_SEL_HI    3
`define DBIT_PPI_BSR_SEL_LO    1
`define DBIT_PPI_BSR_SET_BIT   0
`define DBIT_PPI_PC4_SEL       3'h4
`define DBIT_PPI_PC6_SEL       3'h6

`define DBIT_TCW_SEL_HI        7
`define DBIT_TCW_SEL_LO        6
`define DBIT_TCW_RW_HI         5
`define DBIT_TCW_RW_LO         4
`define DBIT_TCW_MODE_HI       3
`define DBIT_TCW_MODE_LO       1
`define DBIT_TCW_SEL_TIMER0_COUNT_PORT      2'h0
`define DBIT_TCW_SEL_COUNTER_SOURCE_SELECT      2'h1
`define DBIT_TCW_RW_LSB        2'h1
`define DBIT_TCW_RW_MSB        2'h2
`define DBIT_TCW_RW_LSB_MSB    2'h3
`define DBIT_TCW_MODE_RATE     3'h2

`define DBIT_RST_BYTE          8'h00
`define DBIT_RESP_OKAY         2'h0
`define DBIT_RESP_SLVERR       2'h2

`define DBIT_CLK_PERIOD_NS     25
`define DBIT_SRC_PERIOD_NS     500
`define DBIT_SRC_DIV           ((`DBIT_SRC_PERIOD_NS + `DBIT_CLK_PERIOD_NS - 1) / `DBIT_CLK_PERIOD_NS)

`endif

/* logic/dbit_pkg.sv */
// types shared by the board interrupt and timer block
package dbit_pkg;

  typedef enum logic [1:0] {PA_MODE0, PA_MODE1_IN, PA_MODE1_OUT, PA_MODE2} dbit_pa_mode_e;

  typedef enum {
    REG_PORT_IRQ_EN, REG_BOARD_IRQ_CTL, REG_IRQ_CLEAR, REG_PPI_CTL,
    REG_TIMER0_COUNT, REG_TIMER1_COUNT, REG_TIMER_CTL, REG_STATUS, REG_NONE
  } dbit_reg_e;

  typedef struct packed {
    dbit_pa_mode_e mode;
    logic          pc4;
    logic          pc6;
  } dbit_ppi_s;

  typedef struct packed {
    logic [1:0] sel;
    logic [1:0] rw;
    logic [2:0] mode;
  } dbit_tcw_s;

endpackage

/* logic/dbit_counter.sv */
// one rate-generator counter with byte-wise load
`timescale 1ns/1ps
`include "dbit_params.svh"

module dbit_counter #(
  parameter int CNT_W = 16
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              tick,
  input  wire logic              ctl_wr,
  input  wire dbit_pkg::dbit_tcw_s ctl,
  input  wire logic              data_wr,
  input  wire logic [7:0]        data,
  output logic                   out_pulse_q,
  output logic                   running_q,
  output logic [CNT_W-1:0]       count_q
);

  logic [1:0]       rw_q;
  logic [2:0]       mode_q;
  logic [CNT_W-1:0] load_q;
  logic             hi_next_q;
  logic             start;
  logic [CNT_W-1:0] start_val;

  ////////////////////////////////////////////////////////////////
  always_comb begin
    start     = 1'b0;
    start_val = load_q;
    if (data_wr) begin
      unique case (rw_q)
        `DBIT_TCW_RW_LSB: begin
          start     = 1'b1;
          start_val = CNT_W'({8'h00, data});
        end
        `DBIT_TCW_RW_MSB: begin
          start     = 1'b1;
          start_val = CNT_W'({data, 8'h00});
        end
        `DBIT_TCW_RW_LSB_MSB: begin
          start     = hi_next_q;
          start_val = CNT_W'({data, load_q[7:0]});
        end
        default: start = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rw_q      <= 2'h0;
      mode_q    <= 3'h0;
      hi_next_q <= 1'b0;
      load_q    <= '0;
    end else if (ctl_wr) begin
      rw_q      <= ctl.rw;
      mode_q    <= ctl.mode;
      hi_next_q <= 1'b0;
    end else if (data_wr) begin
      if (rw_q == `DBIT_TCW_RW_LSB_MSB && !hi_next_q) begin
        load_q[7:0] <= data;
      end else if (start) begin
        load_q <= start_val;
      end
      if (rw_q == `DBIT_TCW_RW_LSB_MSB) begin
        hi_next_q <= !hi_next_q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      running_q <= 1'b0;
    end else if (ctl_wr) begin
      running_q <= 1'b0;
    end else if (start) begin
      running_q <= (mode_q == `DBIT_TCW_MODE_RATE);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q     <= '0;
      out_pulse_q <= 1'b0;
    end else begin
      out_pulse_q <= 1'b0;
      if (start) begin
        count_q <= start_val;
      end else if (tick && running_q) begin
        // load of zero wraps, giving the full 65536 span
        if (count_q == CNT_W'(1)) begin
          count_q     <= load_q;
          out_pulse_q <= 1'b1;
        end else begin
          count_q <= count_q - CNT_W'(1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reload_on_terminal_a: assert property (tick && running_q && !start && !ctl_wr && count_q == CNT_W'(1)
    |=> out_pulse_q && count_q == $past(load_q)) else $error("counter missed reload");
  start_on_high_a: assert property (data_wr && !ctl_wr && rw_q == `DBIT_TCW_RW_LSB_MSB && hi_next_q
    |=> count_q == {$past(data), $past(load_q[7:0])} && !hi_next_q) else $error("high byte did not load");
  pulse_needs_tick_a: assert property (out_pulse_q |-> $past(tick) && $past(running_q))
    else $error("pulse without source tick");

endmodule // dbit_counter

/* logic/dbit_top.sv */
// board interrupt gating, ppi port a request and cascaded interval timer
`timescale 1ns/1ps
`include "dbit_params.svh"

module dbit_top #(
  parameter int ADDR_W = 8,
  parameter int CNT_W  = 16,
  parameter int SRC_DIV = `DBIT_SRC_DIV
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              porta_input_full,
  input  wire logic              porta_output_empty,
  input  wire logic              porta_ext_line,
  output logic                   host_irq_q
);

  ////////////////////////////////////////////////////////////////
  function automatic dbit_pkg::dbit_reg_e decode(input logic [ADDR_W-1:0] a);
    unique case (a)
      ADDR_W'(`DBIT_OFS_PORT_IRQ_EN):   decode = dbit_pkg::REG_PORT_IRQ_EN;
      ADDR_W'(`DBIT_OFS_BOARD_IRQ_CTL): decode = dbit_pkg::REG_BOARD_IRQ_CTL;
      ADDR_W'(`DBIT_OFS_IRQ_CLEAR):     decode = dbit_pkg::REG_IRQ_CLEAR;
      ADDR_W'(`DBIT_OFS_PPI_CTL):       decode = dbit_pkg::REG_PPI_CTL;
      ADDR_W'(`DBIT_OFS_TIMER0_COUNT):  decode = dbit_pkg::REG_TIMER0_COUNT;
      ADDR_W'(`DBIT_OFS_TIMER1_COUNT):  decode = dbit_pkg::REG_TIMER1_COUNT;
      ADDR_W'(`DBIT_OFS_TIMER_CTL):     decode = dbit_pkg::REG_TIMER_CTL;
      ADDR_W'(`DBIT_OFS_STATUS):        decode = dbit_pkg::REG_STATUS;
      default:                          decode = dbit_pkg::REG_NONE;
    endcase
  endfunction

  logic [ADDR_W-1:0]   awaddr_q;
  logic [7:0]          wbyte_q;
  logic                wlane_q;
  logic                aw_full_q;
  logic                w_full_q;
  logic                aw_full_d;
  logic                w_full_d;
  logic                aw_take;
  logic                w_take;
  logic                b_done;
  logic                wr_go;
  dbit_pkg::dbit_reg_e wr_reg;
  logic                ar_take;
  logic                r_done;

  logic                porta_irq_en_q;
  logic                ctr_src_sel_q;
  logic                ctr_irq_en_q;
  logic                master_en_q;
  dbit_pkg::dbit_ppi_s ppi_q;
  dbit_pkg::dbit_tcw_s tcw;
  logic                wr_pie;
  logic                wr_bic;
  logic                wr_clr;
  logic                wr_ppi;
  logic                wr_tcw;

  ////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  assign aw_take   = s_axi_awvalid && s_axi_awready;
  assign w_take    = s_axi_wvalid && s_axi_wready;
  assign b_done    = s_axi_bvalid && s_axi_bready;
  assign wr_go     = aw_full_q && w_full_q && !s_axi_bvalid;
  assign aw_full_d = (aw_full_q && !b_done) || aw_take;
  assign w_full_d  = (w_full_q && !b_done) || w_take;
  assign wr_reg    = decode(awaddr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      aw_full_q     <= aw_full_d;
      w_full_q      <= w_full_d;
      s_axi_awready <= !aw_full_d;
      s_axi_wready  <= !w_full_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= '0;
      wbyte_q  <= `DBIT_RST_BYTE;
      wlane_q  <= 1'b0;
    end else begin
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DBIT_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_reg == dbit_pkg::REG_NONE) ? `DBIT_RESP_SLVERR : `DBIT_RESP_OKAY;
    end else if (b_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // registers hold one byte, so only lane 0 commits; the irq clear strobe fires whatever the lanes
  assign wr_pie = wr_go && wlane_q && wr_reg == dbit_pkg::REG_PORT_IRQ_EN;
  assign wr_bic = wr_go && wlane_q && wr_reg == dbit_pkg::REG_BOARD_IRQ_CTL;
  assign wr_clr = wr_go && wr_reg == dbit_pkg::REG_IRQ_CLEAR;
  assign wr_ppi = wr_go && wlane_q && wr_reg == dbit_pkg::REG_PPI_CTL;
  assign wr_tcw = wr_go && wlane_q && wr_reg == dbit_pkg::REG_TIMER_CTL;
  assign tcw    = '{sel:  wbyte_q[`DBIT_TCW_SEL_HI:`DBIT_TCW_SEL_LO],
                    rw:   wbyte_q[`DBIT_TCW_RW_HI:`DBIT_TCW_RW_LO],
                    mode: wbyte_q[`DBIT_TCW_MODE_HI:`DBIT_TCW_MODE_LO]};

  ////////////////////////////////////////////////////////////////
  // interrupt control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      porta_irq_en_q <= 1'b0;
    end else if (wr_pie) begin
      porta_irq_en_q <= wbyte_q[`DBIT_PIE_PORTA_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctr_src_sel_q <= 1'b0;
      ctr_irq_en_q  <= 1'b0;
      master_en_q   <= 1'b0;
    end else if (wr_bic) begin
      ctr_src_sel_q <= wbyte_q[`DBIT_BIC_SRC_SEL_BIT];
      ctr_irq_en_q  <= wbyte_q[`DBIT_BIC_CTR_EN_BIT];
      master_en_q   <= wbyte_q[`DBIT_BIC_MASTER_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////
  // peripheral interface control word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ppi_q <= '{mode: dbit_pkg::PA_MODE0, pc4: 1'b0, pc6: 1'b0};
    end else if (wr_ppi) begin
      if (wbyte_q[`DBIT_PPI_MODESET_BIT]) begin
        // mode set, port c enables reset
        ppi_q.pc4 <= 1'b0;
        ppi_q.pc6 <= 1'b0;
        if (wbyte_q[`DBIT_PPI_MODE_HI]) begin
          ppi_q.mode <= dbit_pkg::PA_MODE2;
        end else if (wbyte_q[`DBIT_PPI_MODE_LO]) begin
          ppi_q.mode <= wbyte_q[`DBIT_PPI_DIR_IN_BIT] ? dbit_pkg::PA_MODE1_IN : dbit_pkg::PA_MODE1_OUT;
        end else begin
          ppi_q.mode <= dbit_pkg::PA_MODE0;
        end
      end else begin
        if (wbyte_q[`DBIT_PPI_BSR_SEL_HI:`DBIT_PPI_BSR_SEL_LO] == `DBIT_PPI_PC4_SEL) begin
          ppi_q.pc4 <= wbyte_q[`DBIT_PPI_BSR_SET_BIT];
        end
        if (wbyte_q[`DBIT_PPI_BSR_SEL_HI:`DBIT_PPI_BSR_SEL_LO] == `DBIT_PPI_PC6_SEL) begin
          ppi_q.pc6 <= wbyte_q[`DBIT_PPI_BSR_SET_BIT];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin synchronisers: level moves once stages two and three agree
  localparam int NPIN = 3;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_lvl_q;
  assign pin_raw = {porta_ext_line, porta_output_empty, porta_input_full};

  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    logic [2:0] s_q;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s_q          <= 3'h0;
        pin_lvl_q[i] <= 1'b0;
      end else begin
        s_q <= {s_q[1:0], pin_raw[i]};
        if (s_q[1] == s_q[2]) begin
          pin_lvl_q[i] <= s_q[2];
        end
      end
    end
  end

  logic ext_prev_q;
  logic ext_rise;
  logic ext_pend_q;
  logic porta_req;
  assign ext_rise = pin_lvl_q[2] && !ext_prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev_q <= 1'b0;
      ext_pend_q <= 1'b0;
    end else begin
      ext_prev_q <= pin_lvl_q[2];
      if (ext_rise) begin
        ext_pend_q <= 1'b1;
      end else if (wr_clr) begin
        ext_pend_q <= 1'b0;
      end
    end
  end

  always_comb begin
    porta_req = 1'b0;
    unique case (ppi_q.mode)
      dbit_pkg::PA_MODE0:     porta_req = ext_pend_q;
      dbit_pkg::PA_MODE1_IN:  porta_req = pin_lvl_q[0] && ppi_q.pc4;
      dbit_pkg::PA_MODE1_OUT: porta_req = pin_lvl_q[1] && ppi_q.pc6;
      dbit_pkg::PA_MODE2:     porta_req = (pin_lvl_q[0] && ppi_q.pc4) || (pin_lvl_q[1] && ppi_q.pc6);
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // timer: 2 MHz source, counter 0 prescales counter 1
  localparam int DIV_W = $clog2(SRC_DIV + 1);
  logic [DIV_W-1:0] div_q;
  logic             src_tick_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q      <= '0;
      src_tick_q <= 1'b0;
    end else if (div_q == DIV_W'(SRC_DIV - 1)) begin
      div_q      <= '0;
      src_tick_q <= 1'b1;
    end else begin
      div_q      <= div_q + DIV_W'(1);
      src_tick_q <= 1'b0;
    end
  end

  logic [1:0]       ctr_tick;
  logic [1:0]       ctr_ctl_wr;
  logic [1:0]       ctr_data_wr;
  logic [1:0]       ctr_pulse;
  logic [1:0]       ctr_run;
  logic [CNT_W-1:0] ctr_count [2];

  assign ctr_tick = {ctr_pulse[0], src_tick_q};
  assign ctr_ctl_wr  = {wr_tcw && tcw.sel == `DBIT_TCW_SEL_COUNTER_SOURCE_SELECT, wr_tcw && tcw.sel == `DBIT_TCW_SEL_TIMER0_COUNT_PORT};
  assign ctr_data_wr = {wr_go && wlane_q && wr_reg == dbit_pkg::REG_TIMER1_COUNT,
                        wr_go && wlane_q && wr_reg == dbit_pkg::REG_TIMER0_COUNT};

  // counter 1 counts counter 0 pulses
  for (genvar c = 0; c < 2; c++) begin : g_ctr
    dbit_counter #(.CNT_W(CNT_W)) u_ctr (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .tick        (ctr_tick[c]),
      .ctl_wr      (ctr_ctl_wr[c]),
      .ctl         (tcw),
      .data_wr     (ctr_data_wr[c]),
      .data        (wbyte_q),
      .out_pulse_q (ctr_pulse[c]),
      .running_q   (ctr_run[c]),
      .count_q     (ctr_count[c])
    );
  end

  logic ctr_pend_q;
  logic ctr_sel_pulse;
  assign ctr_sel_pulse = ctr_src_sel_q ? ctr_pulse[1] : ctr_pulse[0];

  // counter pulse is too short to gate directly, so it is held until cleared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctr_pend_q <= 1'b0;
    end else if (ctr_irq_en_q && ctr_sel_pulse) begin
      ctr_pend_q <= 1'b1;
    end else if (wr_clr || !ctr_irq_en_q) begin
      ctr_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_irq_q <= 1'b0;
    end else begin
      host_irq_q <= master_en_q && ((porta_irq_en_q && porta_req) || (ctr_irq_en_q && ctr_pend_q));
    end
  end

  ////////////////////////////////////////////////////////////////
  // read channel, one outstanding read
  dbit_pkg::dbit_reg_e rd_reg;
  logic [7:0]          rd_byte;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign r_done  = s_axi_rvalid && s_axi_rready;
  assign rd_reg  = decode(s_axi_araddr);

  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_reg)
      dbit_pkg::REG_PORT_IRQ_EN:   rd_byte = {7'h00, porta_irq_en_q};
      dbit_pkg::REG_BOARD_IRQ_CTL: rd_byte = {5'h00, master_en_q, ctr_irq_en_q, ctr_src_sel_q};
      dbit_pkg::REG_PPI_CTL:       rd_byte = {4'h0, ppi_q.pc6, ppi_q.pc4, 2'(ppi_q.mode)};
      dbit_pkg::REG_TIMER0_COUNT:  rd_byte = ctr_count[0][7:0];
      dbit_pkg::REG_TIMER1_COUNT:  rd_byte = ctr_count[1][7:0];
      dbit_pkg::REG_STATUS:        rd_byte = {2'h0, host_irq_q, ctr_run[1], ctr_run[0], ctr_pend_q, ext_pend_q,
                                              porta_req};
      dbit_pkg::REG_IRQ_CLEAR,
      dbit_pkg::REG_TIMER_CTL,
      dbit_pkg::REG_NONE:          rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DBIT_RESP_OKAY;
    end else begin
      s_axi_arready <= !(ar_take || (s_axi_rvalid && !s_axi_rready));
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= (rd_reg == dbit_pkg::REG_NONE) ? `DBIT_RESP_SLVERR : `DBIT_RESP_OKAY;
      end else if (r_done) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence bic_write(logic [7:0] v);
    wr_bic && wbyte_q == v;
  endsequence

  sequence tcw_rate_timer0_count_port;
    wr_tcw && wbyte_q == 8'h34;
  endsequence

  src_tick_spacing_a: assert property (src_tick_q |-> ##SRC_DIV src_tick_q)
    else $error("source tick period wrong");
  // counter 1 one cycle behind counter 0
  counter_source_select_chain_a: assert property (ctr_pulse[1] |-> $past(ctr_pulse[0]))
    else $error("counter 1 not fed by counter 0");
  rate_setup_a: assert property (tcw_rate_timer0_count_port |=> !ctr_run[0]) else $error("counter 0 kept running on control word");
  bic_zero_a: assert property (bic_write(8'h00) |=> !master_en_q ##1 !host_irq_q[*3])
    else $error("interrupt survived disable");
  bic_both_a: assert property (bic_write(8'h06) |=> master_en_q && ctr_irq_en_q && !ctr_src_sel_q)
    else $error("board and counter enables not set");
  pie_zero_a: assert property (wr_pie && wbyte_q == 8'h00 |=> !porta_irq_en_q) else $error("port enable not cleared");
  bsr_pc4_a: assert property (wr_ppi && wbyte_q == 8'h09 |=> ppi_q.pc4) else $error("pc4 not set");
  ext_latch_a: assert property (ext_rise |=> ext_pend_q) else $error("external edge lost");
  irq_gate_a: assert property (host_irq_q |-> $past(master_en_q)) else $error("irq without master enable");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");

endmodule // dbit_top

/* sim/dbit_pin_model.sv */
// port a pin model standing in for the far side
`timescale 1ns/1ps
module dbit_pin_model (
  input  wire logic       aclk,
  input  wire logic [2:0] req,
  output logic            porta_input_full = 1'b0,
  output logic            porta_output_empty = 1'b0,
  output logic            porta_ext_line = 1'b0
);
  always @(posedge aclk) begin
    {porta_ext_line, porta_output_empty, porta_input_full} <= req;
  end
endmodule // dbit_pin_model

/* sim/tb.sv */
// bench: axi-lite register sequences and host irq checks
`timescale 1ns/1ps
`include "dbit_params.svh"
module tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, inf, oemp, ext;
  logic [1:0]  bresp, rresp, resp_q;
  logic [31:0] rdata;
  logic [7:0]  rd_q;
  logic [2:0]  pins = 3'h0;
  logic [3:0]  strb = 4'hF;
  int          bad_count = 0;
  int          total_checks = 0;
  logic [7:0]  mw [3] = '{8'hB0, 8'hA0, 8'hC0};
  logic [7:0]  bw [3] = '{8'h09, 8'h0D, 8'h09};
  logic [7:0]  rx [3] = '{8'h05, 8'h0A, 8'h07};
  logic [2:0]  pv [3] = '{3'h1, 3'h2, 3'h1};
  initial forever #12.5 aclk = ~aclk;
  dbit_top #(.SRC_DIV(2)) dbit_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .porta_input_full(inf),
    .porta_output_empty(oemp), .porta_ext_line(ext), .host_irq_q(irq));
  dbit_pin_model dbit_pin_model_inst (.aclk(aclk), .req(pins), .porta_input_full(inf),
    .porta_output_empty(oemp), .porta_ext_line(ext));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int i;
    // an edge between transfers, so no ready is driven twice in one step
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, d}; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    resp_q = bresp;
    if (i == 40) begin bad_count++; complete_run(); end
  endtask
  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a; arv <= 1'b1; rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arready) arv <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rd_q = rdata[7:0];
    resp_q = rresp;
    if (i == 40) begin bad_count++; complete_run(); end
  endtask
  // bounded wait: a missed level counts as a mismatch
  task automatic wirq(input logic e, input int n);
    for (int i = 0; i < n && irq !== e; i++) @(posedge aclk);
    check("host_irq", {7'h0, irq}, {7'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`DBIT_OFS_STATUS); check("status", rd_q, 8'h00);
    rd(8'h20); check("rresp", {6'h0, resp_q}, 8'h02);
    wr(8'h20, 8'h06); check("bresp", {6'h0, resp_q}, 8'h02);
    strb <= 4'hE;
    wr(`DBIT_OFS_PORT_IRQ_EN, 8'h01);
    strb <= 4'hF;
    rd(`DBIT_OFS_PORT_IRQ_EN);
    check("lane0 off", rd_q, 8'h00);
    wr(`DBIT_OFS_PORT_IRQ_EN, 8'h00); wr(`DBIT_OFS_BOARD_IRQ_CTL, 8'h00);
    wr(`DBIT_OFS_TIMER_CTL, 8'h34); wr(`DBIT_OFS_BOARD_IRQ_CTL, 8'h02);
    wr(`DBIT_OFS_BOARD_IRQ_CTL, 8'h06); wr(`DBIT_OFS_TIMER0_COUNT, 8'h08);
    rd(`DBIT_OFS_STATUS); check("timer0_count_port idle", rd_q & 8'h08, 8'h00);
    wr(`DBIT_OFS_TIMER0_COUNT, 8'h00);
    rd(`DBIT_OFS_STATUS); check("timer0_count_port run", rd_q & 8'h08, 8'h08);
    wr(`DBIT_OFS_TIMER_CTL, 8'hB4);
    rd(`DBIT_OFS_STATUS);
    check("ctr2 ignored", rd_q & 8'h18, 8'h08);
    wirq(1'b1, 20);
    wr(`DBIT_OFS_BOARD_IRQ_CTL, 8'h00); wirq(1'b0, 3);
    repeat (20) @(posedge aclk);
    check("irq off", {7'h0, irq}, 8'h00);
    wr(`DBIT_OFS_TIMER_CTL, 8'h74); wr(`DBIT_OFS_TIMER1_COUNT, 8'h02);
    wr(`DBIT_OFS_TIMER1_COUNT, 8'h00); wr(`DBIT_OFS_BOARD_IRQ_CTL, 8'h07);
    wirq(1'b1, 45);
    wr(`DBIT_OFS_BOARD_IRQ_CTL, 8'h00); wr(`DBIT_OFS_TIMER_CTL, 8'h30);
    rd(`DBIT_OFS_STATUS); check("timer0_count_port stop", rd_q & 8'h08, 8'h00);
    wr(`DBIT_OFS_TIMER_CTL, 8'h14);
    wr(`DBIT_OFS_TIMER0_COUNT, 8'h05);
    rd(`DBIT_OFS_STATUS);
    check("timer0_count_port lsb", rd_q & 8'h08, 8'h08);
    for (int k = 0; k < 3; k++) begin
      wr(`DBIT_OFS_PPI_CTL, mw[k]); wr(`DBIT_OFS_PPI_CTL, bw[k]);
      rd(`DBIT_OFS_PPI_CTL); check("ppi mode", rd_q, rx[k]);
      wr(`DBIT_OFS_BOARD_IRQ_CTL, 8'h04); wr(`DBIT_OFS_PORT_IRQ_EN, 8'h01);
      pins <= pv[k];
      wirq(1'b1, 10);
      wr(`DBIT_OFS_BOARD_IRQ_CTL, 8'h00); wirq(1'b0, 3);
      wr(`DBIT_OFS_BOARD_IRQ_CTL, 8'h04); wirq(1'b1, 3);
      wr(`DBIT_OFS_PORT_IRQ_EN, 8'h00); wirq(1'b0, 3);
      pins <= 3'h0;
    end
    wr(`DBIT_OFS_PPI_CTL, 8'h80); wr(`DBIT_OFS_PORT_IRQ_EN, 8'h01);
    pins <= 3'h4;
    wirq(1'b1, 10);
    pins <= 3'h0;
    repeat (8) @(posedge aclk);
    check("latched", {7'h0, irq}, 8'h01);
    wr(`DBIT_OFS_IRQ_CLEAR, 8'h00); wirq(1'b0, 3);
    complete_run();
  end
endmodule // tb
